/* File: src/periodic_modulo_tick_counter.v */
// Periodic modulo tick counter with AXI4-Lite register access
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module periodic_modulo_tick_counter
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        ce,
   input  wire        low_power_osc_clock,
   input  wire        external_ref_clock,
   input  wire        internal_ref_clock,
   input  wire        debug_freeze,
   input  wire [5:0]  s_axi_awaddr,
   input  wire [2:0]  s_axi_awprot,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [5:0]  s_axi_araddr,
   input  wire [2:0]  s_axi_arprot,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg         tick_irq
);

`include "tick_consts.vh"

   // Register state
   reg  [7:0]  tick_count_r;
   reg  [7:0]  tick_modulo_r;
   reg         tick_flag_r;
   reg         tick_irq_enable_r;
   reg  [1:0]  tick_source_select_r;
   reg  [3:0]  tick_prescale_select_r;

   // Write channel holding
   reg         aw_held_r;
   reg  [5:0]  aw_addr_r;
   reg         w_held_r;
   reg  [31:0] w_data_r;
   reg  [3:0]  w_strb_r;

   // Source synchronisers
   reg  [2:0]  src_meta_r;
   reg  [2:0]  src_sync_r;
   reg         src_prev_r;
   wire        src_level;
   wire        src_edge;
   wire        pre_tick;

   wire        wr_go;
   wire [1:0]  wr_sel;
   wire        wr_ctrl;
   wire        wr_mod;
   wire [7:0]  wbyte;
   wire        src_change;
   wire        ps_change;
   wire        pre_clear;
   reg  [7:0]  status_ctrl_view;

   // Register decode from a word address
   function [1:0] reg_select;
      input [5:0] addr;
      begin
         if ({addr[5:2], 2'b00} == `TICK_OFS_STATUS_CTRL)
            reg_select = `TICK_SEL_STATUS_CTRL;
         else if ({addr[5:2], 2'b00} == `TICK_OFS_COUNT)
            reg_select = `TICK_SEL_COUNT;
         else if ({addr[5:2], 2'b00} == `TICK_OFS_MODULO)
            reg_select = `TICK_SEL_MODULO;
         else
            reg_select = `TICK_SEL_NONE;
      end
   endfunction

   // Two flip-flops on every source clock pin
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         src_meta_r <= 3'h0;
         src_sync_r <= 3'h0;
      end
      else if (ce)
      begin
         src_meta_r <= {internal_ref_clock, external_ref_clock, low_power_osc_clock};
         src_sync_r <= src_meta_r;
      end
   end

   // Source decode: 00 low-power, 01 external, 1x internal
   assign src_level = tick_source_select_r[1] ? src_sync_r[2] :
                      (tick_source_select_r == `TICK_SRC_EXT) ? src_sync_r[1] : src_sync_r[0];
   assign src_edge  = src_level & ~src_prev_r;

   // Bus handshakes
   assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   assign wr_go   = aw_held_r & w_held_r & ~s_axi_bvalid;
   assign wr_sel  = reg_select(aw_addr_r);
   assign wbyte   = w_data_r[7:0];
   assign wr_ctrl = wr_go & w_strb_r[0] & (wr_sel == `TICK_SEL_STATUS_CTRL);
   assign wr_mod  = wr_go & w_strb_r[0] & (wr_sel == `TICK_SEL_MODULO);

   assign src_change = wr_ctrl & (wbyte[`TICK_SRC_HI:`TICK_SRC_LO] != tick_source_select_r);
   assign ps_change  = wr_ctrl & (wbyte[`TICK_PS_HI:`TICK_PS_LO] != tick_prescale_select_r);
   assign pre_clear  = wr_mod | src_change | ps_change;

   always @*
   begin
      status_ctrl_view = {tick_flag_r, tick_source_select_r, tick_irq_enable_r, tick_prescale_select_r};
   end

   // Write channel: address and data taken in either order
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r    <= 1'b0;
         aw_addr_r    <= 6'h00;
         w_held_r     <= 1'b0;
         w_data_r     <= 32'h00000000;
         w_strb_r     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `AXI_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_sel == `TICK_SEL_NONE) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel: answer one cycle after the address is taken
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `AXI_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `AXI_RESP_OKAY;
            if (reg_select(s_axi_araddr) == `TICK_SEL_STATUS_CTRL)
               s_axi_rdata <= {24'h000000, status_ctrl_view};
            else if (reg_select(s_axi_araddr) == `TICK_SEL_COUNT)
               s_axi_rdata <= {24'h000000, tick_count_r};
            else if (reg_select(s_axi_araddr) == `TICK_SEL_MODULO)
               s_axi_rdata <= {24'h000000, tick_modulo_r};
            else
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `AXI_RESP_SLVERR;
            end
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Control fields
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tick_modulo_r          <= `TICK_MODULO_RESET;
         tick_source_select_r   <= `TICK_SRC_RESET;
         tick_prescale_select_r <= `TICK_PS_OFF;
         tick_irq_enable_r      <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_ctrl)
         begin
            tick_source_select_r   <= wbyte[`TICK_SRC_HI:`TICK_SRC_LO];
            tick_prescale_select_r <= wbyte[`TICK_PS_HI:`TICK_PS_LO];
            tick_irq_enable_r      <= wbyte[`TICK_IRQ_EN_BIT];
         end
         if (wr_mod)
            tick_modulo_r <= wbyte;
      end
   end

   // Edge detector restarts on the new source; a pin already high is no edge
   always @(posedge aclk)
   begin
      if (!aresetn)
         src_prev_r <= 1'b0;
      else if (ce)
      begin
         if (src_change)
            src_prev_r <= 1'b1;
         else
            src_prev_r <= src_level;
      end
   end

   tick_prescaler u_prescaler
   (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .ce           (ce),
      .src_edge     (src_edge),
      .run          (~debug_freeze),
      .clear        (pre_clear),
      .prescale_sel (tick_prescale_select_r),
      .src_bit0     (tick_source_select_r[0]),
      .tick_out     (pre_tick)
   );

   // Modulo counter and sticky flag
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tick_count_r <= `TICK_COUNT_RESET;
         tick_flag_r  <= 1'b0;
      end
      else if (ce)
      begin
         if (pre_clear)
            tick_count_r <= `TICK_COUNT_RESET;
         else if (pre_tick && !debug_freeze)
         begin
            if (tick_count_r == tick_modulo_r)
               tick_count_r <= `TICK_COUNT_RESET;
            else
               tick_count_r <= tick_count_r + 8'h01;
         end
         if (!pre_clear && pre_tick && !debug_freeze && tick_count_r == tick_modulo_r)
            tick_flag_r <= 1'b1;
         else if (wr_ctrl && wbyte[`TICK_FLAG_BIT])
            tick_flag_r <= 1'b0;
      end
   end

   // Level interrupt
   always @(posedge aclk)
   begin
      if (!aresetn)
         tick_irq <= 1'b0;
      else if (ce)
         tick_irq <= tick_flag_r & tick_irq_enable_r;
   end

endmodule

`default_nettype wire

/* File: src/tick_consts.vh */
// Offsets, field positions, reset values and response codes of the periodic tick counter
`ifndef TICK_CONSTS_VH
`define TICK_CONSTS_VH

`define TICK_ADDR_W            6
`define TICK_OFS_STATUS_CTRL   6'h00
`define TICK_OFS_COUNT         6'h04
`define TICK_OFS_MODULO        6'h08

`define TICK_SEL_NONE          2'h0
`define TICK_SEL_STATUS_CTRL   2'h1
`define TICK_SEL_COUNT         2'h2
`define TICK_SEL_MODULO        2'h3

`define TICK_FLAG_BIT          7
`define TICK_SRC_HI            6
`define TICK_SRC_LO            5
`define TICK_IRQ_EN_BIT        4
`define TICK_PS_HI             3
`define TICK_PS_LO             0

`define TICK_SRC_LPO           2'h0
`define TICK_SRC_EXT           2'h1

`define TICK_PS_OFF            4'h0
`define TICK_COUNT_RESET       8'h00
`define TICK_MODULO_RESET      8'h00
`define TICK_SRC_RESET         2'h0
`define TICK_PRE_W             18

`define AXI_RESP_OKAY          2'h0
`define AXI_RESP_SLVERR        2'h2

`endif

/* File: src/tick_prescaler.v */
// Prescaler dividing source clock edges by the selected binary or decimal ratio
`timescale 1ns/1ps
`default_nettype none

module tick_prescaler
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        ce,
   input  wire        src_edge,
   input  wire        run,
   input  wire        clear,
   input  wire [3:0]  prescale_sel,
   input  wire        src_bit0,
   output reg         tick_out
);

`include "tick_consts.vh"

   reg  [`TICK_PRE_W-1:0] pre_r;
   wire [`TICK_PRE_W-1:0] last_count;

   // Last count of one period, the ratio minus one
   function [`TICK_PRE_W-1:0] ratio_last;
      input [3:0] sel;
      input       hi;
      reg   [`TICK_PRE_W-1:0] r;
      begin
         r = 18'h00001;
         case ({hi, sel})
            5'h01: r = 18'h00008;
            5'h02: r = 18'h00020;
            5'h03: r = 18'h00040;
            5'h04: r = 18'h00080;
            5'h05: r = 18'h00100;
            5'h06: r = 18'h00200;
            5'h07: r = 18'h00400;
            5'h08: r = 18'h00001;
            5'h09: r = 18'h00002;
            5'h0A: r = 18'h00004;
            5'h0B: r = 18'h0000A;
            5'h0C: r = 18'h00010;
            5'h0D: r = 18'h00064;
            5'h0E: r = 18'h001F4;
            5'h0F: r = 18'h003E8;
            5'h11: r = 18'h00400;
            5'h12: r = 18'h00800;
            5'h13: r = 18'h01000;
            5'h14: r = 18'h02000;
            5'h15: r = 18'h04000;
            5'h16: r = 18'h08000;
            5'h17: r = 18'h10000;
            5'h18: r = 18'h003E8;
            5'h19: r = 18'h007D0;
            5'h1A: r = 18'h01388;
            5'h1B: r = 18'h02710;
            5'h1C: r = 18'h04E20;
            5'h1D: r = 18'h0C350;
            5'h1E: r = 18'h186A0;
            5'h1F: r = 18'h30D40;
            default: r = 18'h00001;
         endcase
         ratio_last = r - 18'h00001;
      end
   endfunction

   assign last_count = ratio_last(prescale_sel, src_bit0);

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pre_r    <= {`TICK_PRE_W{1'b0}};
         tick_out <= 1'b0;
      end
      else if (ce)
      begin
         tick_out <= 1'b0;
         if (clear)
            pre_r <= {`TICK_PRE_W{1'b0}};
         else if (run && prescale_sel != `TICK_PS_OFF && src_edge)
         begin
            if (pre_r >= last_count)
            begin
               pre_r    <= {`TICK_PRE_W{1'b0}};
               tick_out <= 1'b1;
            end
            else
               pre_r <= pre_r + 18'h00001;
         end
      end
   end

endmodule

`default_nettype wire

/* File: tb/periodic_modulo_tick_counter_properties.sv */
// Assertions on the register bus and interrupt of the tick counter
`timescale 1ns/1ps
`default_nettype none
module periodic_modulo_tick_counter_properties
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [5:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [5:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        tick_irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
      else $error("no write response");
   a_write_stall: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property (rd_take |=> s_axi_rvalid)
      else $error("no read response");
   a_read_stall: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_unmapped_err: assert property (
      rd_take ##0 s_axi_araddr == 6'h0C |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read accepted");
   a_irq_masked: assert property (
      wr_take ##0 (s_axi_awaddr == 6'h00 && s_axi_wstrb[0] && !s_axi_wdata[4]) |-> ##3 !tick_irq)
      else $error("irq kept after disable");
endmodule

bind periodic_modulo_tick_counter periodic_modulo_tick_counter_properties u_periodic_modulo_tick_counter_properties (.*);
`default_nettype wire

/* File: tb/periodic_modulo_tick_counter_tb.sv */
// Self-checking bench for the periodic modulo tick counter
`timescale 1ns/1ps
`default_nettype none
module periodic_modulo_tick_counter_tb;
   logic        aclk, aresetn, ce, debug_freeze;
   logic        low_power_osc_clock, external_ref_clock, internal_ref_clock;
   logic [5:0]  s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tick_irq;
   integer      n_mismatch, n_checks, seed, k, i, cnt, pre, md, ps, src, ie, flg;
   integer      ratio [0:15] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000};
   integer      ratio_hi [0:15] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536,
                                    1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000};

   periodic_modulo_tick_counter u_periodic_modulo_tick_counter (.*);

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task finish_test;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      begin
         n_checks = n_checks + 1;
         if (g !== e)
         begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %s expected %h seen %h", nm, e, g);
         end
      end
   endtask

   task automatic tmo(input integer n);
      begin
         if (n >= 50)
         begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value bus wait expected answer seen none");
            finish_test;
         end
      end
   endtask

   // bready is held off for the first cycle and rises in the same cycle as bvalid, so the response is not stalled
   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      integer n;
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= v;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         n = 0;
         do
         begin
            @(posedge aclk);
            if (s_axi_awready)
               s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
               s_axi_wvalid <= 1'b0;
            n = n + 1;
            if (n > 1)
               s_axi_bready <= 1'b1;
         end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
         s_axi_bready <= 1'b0;
         tmo(n);
         chk("bresp", (a > 6'h08) ? 32'h2 : 32'h0, {30'h0, s_axi_bresp});
      end
   endtask

   task automatic rc(input logic [5:0] a, input logic [31:0] e, input string nm);
      integer n;
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         n = 0;
         do
         begin
            @(posedge aclk);
            if (s_axi_arready)
               s_axi_arvalid <= 1'b0;
            n = n + 1;
            if (n > 1)
               s_axi_rready <= 1'b1;
         end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
         s_axi_rready <= 1'b0;
         tmo(n);
         chk(nm, e, s_axi_rdata);
         chk("resp", (a > 6'h08) ? 32'h2 : 32'h0, {30'h0, s_axi_rresp});
      end
   endtask

   // Source edges on the selected pin only, with the model stepped per edge
   task automatic pulses(input integer n);
      begin
         repeat (n)
         begin
            low_power_osc_clock <= (src == 0);
            external_ref_clock <= (src == 1);
            internal_ref_clock <= (src > 1);
            repeat (10) @(posedge aclk);
            low_power_osc_clock <= 1'b0;
            external_ref_clock <= 1'b0;
            internal_ref_clock <= 1'b0;
            repeat (10) @(posedge aclk);
            if (ps != 0 && !debug_freeze && ce)
               pre = pre + 1;
            if (ps != 0 && pre == (src[0] ? ratio_hi[ps] : ratio[ps]))
            begin
               pre = 0;
               flg = flg | (cnt == md);
               cnt = (cnt == md) ? 0 : cnt + 1;
            end
         end
      end
   endtask

   task automatic cfg(input integer s, input integer p, input integer e, input integer c);
      begin
         if (s != src || p != ps)
            pre = 0;
         if (s != src || p != ps)
            cnt = 0;
         src = s;
         ps = p;
         ie = e;
         if (c)
            flg = 0;
         wr(6'h00, {24'h0, c[0], s[1:0], e[0], p[3:0]});
      end
   endtask

   task automatic setm(input integer m);
      begin
         md = m;
         cnt = 0;
         pre = 0;
         wr(6'h08, m);
      end
   endtask

   task automatic chkall;
      begin
         rc(6'h00, {24'h0, flg[0], src[1:0], ie[0], ps[3:0]}, "status");
         rc(6'h04, cnt, "count");
         rc(6'h08, md, "modulo");
         chk("irq", flg & ie, tick_irq);
      end
   endtask

   initial
   begin
      n_mismatch = 0;
      n_checks = 0;
      seed = 32'h293A;
      {cnt, pre, md, ps, src, ie, flg} = '0;
      {aresetn, debug_freeze, low_power_osc_clock, external_ref_clock, internal_ref_clock} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      ce = 1'b1;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chkall;
      rc(6'h0C, 32'h0, "unmapped");
      wr(6'h0C, 32'h0);
      wr(6'h04, 32'h55);
      pulses(3);
      chkall;
      $display("test reset and read-only done");
      setm(2);
      cfg(0, 8, 0, 0);
      pulses(3);
      chkall;
      cfg(0, 8, 1, 0);
      chkall;
      cfg(0, 8, 0, 1);
      chkall;
      $display("test wrap and interrupt done");
      for (i = 0; i < 16; i = i + 1)
      begin
         k = $random(seed);
         if (k[5])
            setm(k[4:3]);
         cfg(k[2] * 2, 8 + k[1:0], k[6], 0);
         pulses(k[10:7]);
         chkall;
         cfg(src, ps, ie, 1);
      end
      $display("test random settings done");
      setm(8'hFF);
      cfg(2, 9, 1, 0);
      pulses(4);
      debug_freeze <= 1'b1;
      pulses(4);
      debug_freeze <= 1'b0;
      ce <= 1'b0;
      pulses(2);
      ce <= 1'b1;
      pulses(2);
      chkall;
      $display("test freeze done");
      setm(0);
      cfg(1, 8, 1, 1);
      pulses(999);
      chkall;
      pulses(1);
      chkall;
      $display("test external source done");
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      {cnt, pre, md, ps, src, ie, flg} = '0;
      @(posedge aclk);
      chkall;
      $display("test second reset done");
      finish_test;
   end
endmodule
`default_nettype wire
